// >>> hw/plf_defines.vh
// Constants for the synthesizer function and start-up setup logic
`ifndef PLF_DEFINES_VH
`define PLF_DEFINES_VH

// Serial word layout
`define PLF_WORD_W 24
`define PLF_SEL_LSB 0
`define PLF_SEL_W 2

// Latch select codes
`define PLF_SEL_REF 2'h0
`define PLF_SEL_FEED 2'h1
`define PLF_SEL_FUNC 2'h2
`define PLF_SEL_INIT 2'h3

// Function and start-up word fields
`define PLF_CLEAR_BIT 2
`define PLF_PD_ARM_BIT 3
`define PLF_POL_BIT 7
`define PLF_TRI_BIT 8
`define PLF_FL_EN_BIT 9
`define PLF_FL_MODE_BIT 11
`define PLF_TMO_LSB 11
`define PLF_TMO_MSB 14
`define PLF_PD_SYNC_BIT 19

// Feedback divider word pump boost bit
`define PLF_BOOST_BIT 21

// Reset values
`define PLF_FUNC_RESET 24'h000000
`define PLF_WORD_RESET 24'h000000

// Timeout decode: cycles = base + step * field
`define PLF_TMO_BASE 6'h03
`define PLF_TMO_STEP 6'h04
`define PLF_TMO_CNT_W 6

`endif

// >>> hw/plf_sync.v
// Two flip-flop synchroniser for a group of asynchronous pins
`timescale 1ns/1ps
`default_nettype none

module plf_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  // Clock and reset
  input wire clock,
  input wire reset_n,
  // Pins in, synchronised copies out
  input wire [WIDTH-1:0] pin_in,
  output reg [WIDTH-1:0] pin_sync
);

  reg [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= RESET_VAL;
      pin_sync <= RESET_VAL;
    end else begin
      meta_q <= pin_in;
      pin_sync <= meta_q;
    end
  end

endmodule

`default_nettype wire

// >>> hw/plf_top.v
// Setup word receiver, power-down, counter reset and fastlock control
`timescale 1ns/1ps
`default_nettype none
`include "plf_defines.vh"

// How it works
// - Select bits 1,0 store the function word
// - Clear bit holds dividers; release restarts aligned
// - Chip activate low powers down at once
// - Arm with sync select 0 powers down immediately
// - Arm with sync select 1 waits pump event
// - Power-down loads counters, tristates pump, resets lock
// - Serial words accepted during power-down, settings kept
// - Bit 7 picks phase detector polarity
// - Three-state bit puts pump in high impedance
// - Fastlock only while bit 9 is set
// - Bit 11 picks manual or timed fastlock
// - Fastlock off: switch output follows bit 11
// - In fastlock: switch low, pump current high
// - Variant one: boost bit enters and leaves
// - Variant two: timeout clears stored boost bit
// - Bits 14..11 set the high current duration
// - Select bits 1,1 load settings plus reset pulse
// - Start-up word reset pulse does not power down
// - First feedback word after start-up pulses again
// - Clear start-up holds counters without sync power-down
module plf_top #(
  parameter WORD_W = `PLF_WORD_W
) (
  // Clock and reset
  input wire clock,
  input wire reset_n,
  // Three-wire serial link and chip activate pin
  input wire ser_clk,
  input wire ser_data,
  input wire ser_latch,
  input wire chip_activate,
  // Charge pump event, one pulse per phase detector cycle
  input wire pump_event,
  // Divider control
  output reg counter_load_q,
  output reg reset_pulse_q,
  output reg [WORD_W-1:0] ref_word_q,
  output reg [WORD_W-1:0] feed_word_q,
  // Power state
  output reg powered_down_q,
  output reg lock_detect_reset_q,
  // Charge pump and loop filter
  output reg detector_polarity_bit_q,
  output reg pump_tristate_q,
  output reg pump_high_current_q,
  output reg loop_filter_switch_output_q
);

  // Timeout terminal count for a timeout field value
  function [`PLF_TMO_CNT_W-1:0] tmo_limit;
    input [3:0] field;
    begin
      tmo_limit = `PLF_TMO_BASE + ({2'h0, field} * `PLF_TMO_STEP);
    end
  endfunction

  // Transfer strobe for one latch select code
  function sel_hit;
    input strobe;
    input [1:0] code;
    input [1:0] want;
    begin
      sel_hit = strobe & (code == want);
    end
  endfunction

  // Synchronised pins
  wire sclk_s;
  wire sdata_s;
  wire latch_s;
  wire ce_s;

  // Serial front end
  reg sclk_d1_q;
  reg latch_d1_q;
  reg [WORD_W-1:0] shift_q;
  wire sclk_rise;
  wire latch_rise;
  wire [1:0] sel;

  // Stored setup
  reg [WORD_W-1:0] func_q;
  reg boost_q;
  reg first_feed_armed_q;
  reg sync_pd_q;
  reg [`PLF_TMO_CNT_W-1:0] tmo_cnt_q;

  // Decoded strobes and levels
  wire take_ref;
  wire take_feed;
  wire take_func;
  wire take_init;
  wire pd_arm;
  wire pd_sync_sel;
  wire fl_enable;
  wire fl_mode_timed;
  wire clear_on;
  wire in_fastlock;
  wire tmo_expired;
  wire tmo_at_limit;
  wire fl_timed_run;
  wire fl_high_now;
  wire [3:0] tmo_field;
  wire pulse_now;
  reg power_down_now;

  // Pins come from outside the clock domain; chip activate resets low
  plf_sync #(
    .WIDTH(4),
    .RESET_VAL(4'h0)
  ) u_sync (
    .clock(clock),
    .reset_n(reset_n),
    .pin_in({ser_clk, ser_data, ser_latch, chip_activate}),
    .pin_sync({sclk_s, sdata_s, latch_s, ce_s})
  );

  // Edge finders on the synchronised serial clock and latch enable
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sclk_d1_q <= 1'b0;
      latch_d1_q <= 1'b0;
    end else begin
      sclk_d1_q <= sclk_s;
      latch_d1_q <= latch_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_d1_q;
  assign latch_rise = latch_s & ~latch_d1_q;

  // Input shift register, always active, first bit ends at the top
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      shift_q <= `PLF_WORD_RESET;
    end else if (sclk_rise) begin
      shift_q <= {shift_q[WORD_W-2:0], sdata_s};
    end
  end

  // Latch select is the last two bits clocked in
  assign sel = shift_q[`PLF_SEL_LSB+1:`PLF_SEL_LSB];
  assign take_ref = sel_hit(latch_rise, sel, `PLF_SEL_REF);
  assign take_feed = sel_hit(latch_rise, sel, `PLF_SEL_FEED);
  assign take_func = sel_hit(latch_rise, sel, `PLF_SEL_FUNC);
  assign take_init = sel_hit(latch_rise, sel, `PLF_SEL_INIT);

  // Function settings from either the function or the start-up word
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      func_q <= `PLF_FUNC_RESET;
    end else if (take_func | take_init) begin
      func_q <= shift_q;
    end
  end

  // Reference divider word; kept through any power-down
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ref_word_q <= `PLF_WORD_RESET;
    end else if (take_ref) begin
      ref_word_q <= shift_q;
    end
  end

  // Feedback divider word; its stored boost bit drops when the timeout ends
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      feed_word_q <= `PLF_WORD_RESET;
    end else if (take_feed) begin
      feed_word_q <= shift_q;
    end else if (tmo_expired) begin
      feed_word_q[`PLF_BOOST_BIT] <= 1'b0;
    end
  end

  // Field views of the function settings
  assign clear_on = func_q[`PLF_CLEAR_BIT];
  assign pd_arm = func_q[`PLF_PD_ARM_BIT];
  assign pd_sync_sel = func_q[`PLF_PD_SYNC_BIT];
  assign fl_enable = func_q[`PLF_FL_EN_BIT];
  assign fl_mode_timed = func_q[`PLF_FL_MODE_BIT];
  assign tmo_field = func_q[`PLF_TMO_MSB:`PLF_TMO_LSB];

  // Start-up pulse tracking: first feedback word after start-up fires again
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      first_feed_armed_q <= 1'b0;
    end else if (take_init) begin
      first_feed_armed_q <= 1'b1;
    end else if (take_feed) begin
      first_feed_armed_q <= 1'b0;
    end
  end

  assign pulse_now = take_init | (take_feed & first_feed_armed_q);

  // Synchronous power-down waits for the next charge pump event
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sync_pd_q <= 1'b0;
    end else if (!(pd_arm & pd_sync_sel)) begin
      sync_pd_q <= 1'b0;
    end else if (pump_event) begin
      sync_pd_q <= 1'b1;
    end
  end

  // Any source of power-down; clear bit alone is not one
  always @* begin
    power_down_now = 1'b0;
    if (!ce_s) begin
      power_down_now = 1'b1;
    end
    if (pd_arm & ~pd_sync_sel) begin
      power_down_now = 1'b1;
    end
    if (sync_pd_q) begin
      power_down_now = 1'b1;
    end
  end

  // Fastlock is active while enabled and the stored boost bit is set
  assign in_fastlock = fl_enable & boost_q;

  // Timed variant runs its timeout only while fastlock is on
  assign fl_timed_run = in_fastlock & fl_mode_timed;

  // Timeout reached on the detector cycle that completes the count
  assign tmo_at_limit = tmo_cnt_q >= (tmo_limit(tmo_field) - 6'h01);
  assign tmo_expired = fl_timed_run & pump_event & tmo_at_limit;

  // Timeout counter counts detector cycles; loaded by power-down
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tmo_cnt_q <= {`PLF_TMO_CNT_W{1'b0}};
    end else if (power_down_now | pulse_now | take_feed) begin
      tmo_cnt_q <= {`PLF_TMO_CNT_W{1'b0}};
    end else if (!fl_timed_run) begin
      tmo_cnt_q <= {`PLF_TMO_CNT_W{1'b0}};
    end else if (pump_event & ~tmo_expired) begin
      tmo_cnt_q <= tmo_cnt_q + 6'h01;
    end
  end

  // Stored boost bit: written by feedback word, cleared by timeout
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      boost_q <= 1'b0;
    end else if (take_feed) begin
      boost_q <= shift_q[`PLF_BOOST_BIT];
    end else if (tmo_expired) begin
      boost_q <= 1'b0;
    end
  end

  // High current stands in fastlock until a timeout ends it
  assign fl_high_now = in_fastlock & ~tmo_expired;

  // Counters held at load state by power-down, clear bit or reset pulse
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      counter_load_q <= 1'b1;
    end else begin
      counter_load_q <= power_down_now | clear_on | pulse_now;
    end
  end

  // Internal divider reset pulse, one cycle per firing
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      reset_pulse_q <= 1'b0;
    end else begin
      reset_pulse_q <= pulse_now;
    end
  end

  // Power state; stored settings are untouched by it
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      powered_down_q <= 1'b1;
    end else begin
      powered_down_q <= power_down_now;
    end
  end

  // Lock detect held in reset through any power-down
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      lock_detect_reset_q <= 1'b1;
    end else begin
      lock_detect_reset_q <= power_down_now;
    end
  end

  // Phase detector polarity follows the stored setting
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      detector_polarity_bit_q <= 1'b0;
    end else begin
      detector_polarity_bit_q <= func_q[`PLF_POL_BIT];
    end
  end

  // Pump high impedance on request, power-down, clear or reset pulse
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pump_tristate_q <= 1'b1;
    end else begin
      pump_tristate_q <= func_q[`PLF_TRI_BIT]
        | power_down_now | clear_on | pulse_now;
    end
  end

  // Pump current high only while in fastlock
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pump_high_current_q <= 1'b0;
    end else begin
      pump_high_current_q <= fl_high_now;
    end
  end

  // Loop filter switch: plain output with fastlock off, low in fastlock
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      loop_filter_switch_output_q <= 1'b0;
    end else if (!fl_enable) begin
      loop_filter_switch_output_q <= func_q[`PLF_FL_MODE_BIT];
    end else begin
      loop_filter_switch_output_q <= ~fl_high_now;
    end
  end

endmodule

`default_nettype wire

// >>> test/plf_top_properties.sv
// Port checks for the setup word logic
`timescale 1ns/1ps
`default_nettype none
module plf_top_properties #(
  parameter WORD_W = 24
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Pins
  input wire logic ser_latch,
  input wire logic chip_activate,
  input wire logic pump_event,
  // Outputs
  input wire logic counter_load_q,
  input wire logic reset_pulse_q,
  input wire logic [WORD_W-1:0] ref_word_q,
  input wire logic powered_down_q,
  input wire logic lock_detect_reset_q,
  input wire logic pump_tristate_q,
  input wire logic pump_high_current_q,
  input wire logic loop_filter_switch_output_q
);
  // Shared clock and reset for all checks
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Power, pump and latch relations
  property p_ce_pd;
    !chip_activate [*4] |-> powered_down_q;
  endproperty
  a_ce_pd: assert property (p_ce_pd) else $error("pin power-down late");
  property p_pd_all;
    powered_down_q [*2] |-> counter_load_q && pump_tristate_q && lock_detect_reset_q;
  endproperty
  a_pd_all: assert property (p_pd_all) else $error("power-down effects missing");
  property p_load_tri;
    counter_load_q && $past(counter_load_q) |-> pump_tristate_q;
  endproperty
  a_load_tri: assert property (p_load_tri) else $error("pump not tristated");
  property p_pulse;
    reset_pulse_q |=> !reset_pulse_q;
  endproperty
  a_pulse: assert property (p_pulse) else $error("reset pulse too long");
  property p_fl_low;
    pump_high_current_q [*2] |-> !loop_filter_switch_output_q;
  endproperty
  a_fl_low: assert property (p_fl_low) else $error("switch high in fastlock");
  property p_ref_latch;
    !$stable(ref_word_q) |-> $past(ser_latch, 3);
  endproperty
  a_ref_latch: assert property (p_ref_latch) else $error("word changed unlatched");
  property p_pd_cause;
    $rose(powered_down_q) && $past(chip_activate, 3) |-> $past(ser_latch, 4) ||
      $past(pump_event, 2) || $past(pump_event, 3);
  endproperty
  a_pd_cause: assert property (p_pd_cause) else $error("power-down uncaused");
  property p_hi_fall;
    $fell(pump_high_current_q) |-> $past(ser_latch, 4) || $past(pump_event);
  endproperty
  a_hi_fall: assert property (p_hi_fall) else $error("high current dropped");
endmodule
`default_nettype wire

// >>> test/plf_host.sv
// Host model writing setup words over the three-wire link
`timescale 1ns/1ps
`default_nettype none
module plf_host (
  // Pacing clock
  input wire logic clock,
  // Link pins
  output logic ser_clk,
  output logic ser_data,
  output logic ser_latch
);
  // Link starts low; clock and latch idle low
  initial begin
    ser_clk = 0;
    ser_data = 0;
    ser_latch = 0;
  end
  // One word, bit 23 first, then a latch pulse; 800 ns link period
  task automatic send(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      ser_data = w[i];
      repeat (4) @(negedge clock);
      ser_clk = 1;
      repeat (4) @(negedge clock);
      ser_clk = 0;
    end
    ser_data = ~w[0]; // No stale level once released
    repeat (4) @(negedge clock);
    ser_latch = 1;
    repeat (4) @(negedge clock);
    ser_latch = 0;
  endtask
endmodule
`default_nettype wire

// >>> test/tb_top.sv
// Self-checking bench for the setup word logic
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock = 0, reset_n = 0, chip_activate = 1, pump_event = 0;
  wire logic ser_clk, ser_data, ser_latch, counter_load_q, reset_pulse_q, powered_down_q;
  wire logic lock_detect_reset_q, detector_polarity_bit_q, pump_tristate_q;
  wire logic pump_high_current_q, loop_filter_switch_output_q;
  wire logic [23:0] ref_word_q, feed_word_q;
  int num_errors = 0, num_checks = 0, pulses = 0, exp_pulses = 0, n;
  logic [23:0] fw = 0, rw = 0, nw = 0;
  logic boost = 0, spd = 0, armed = 0, pd, cl, hi;
  logic [3:0] f;
  plf_top i_dut (.*);
  plf_host i_host (.*);
  // Clock and reset pulse counter
  always #50 clock = ~clock;
  always @(posedge clock) if (reset_pulse_q === 1'b1) pulses++;
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s exp %h seen %h", what, exp, seen);
    end
  endtask
  // Model of every output
  task automatic chk_all();
    pd = !chip_activate | (fw[3] & !fw[19]) | spd;
    cl = pd | fw[2];
    hi = fw[9] & boost;
    check("pd", powered_down_q, pd);
    check("lock", lock_detect_reset_q, pd);
    check("load", counter_load_q, cl);
    check("tri", pump_tristate_q, cl | fw[8]);
    check("pol", detector_polarity_bit_q, fw[7]);
    check("hi", pump_high_current_q, hi);
    check("lfs", loop_filter_switch_output_q, fw[9] ? !hi : fw[11]);
    check("ref", ref_word_q, rw);
    check("feed", feed_word_q, {nw[23:22], boost, nw[20:0]});
    check("pulses", pulses, exp_pulses);
  endtask
  task automatic wr(input logic [1:0] sel, input logic [23:0] w);
    w[1:0] = sel;
    if (sel[1]) fw = w;
    if (sel[1] && !(w[3] && w[19])) spd = 0;
    if (sel == 2'h0) rw = w;
    if (sel == 2'h1) begin
      nw = w;
      boost = w[21];
      exp_pulses += armed;
      armed = 0;
    end
    if (sel == 2'h3) begin
      exp_pulses++;
      armed = 1;
    end
    i_host.send(w);
    repeat (2) @(negedge clock);
    chk_all();
  endtask
  task automatic pulse(input int k);
    repeat (k) begin
      @(negedge clock) pump_event = 1;
      @(negedge clock) pump_event = 0;
    end
    repeat (4) @(negedge clock);
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Watchdog
  initial begin
    #3_000_000;
    num_errors++;
    end_of_test();
  end
  // Main sequence
  initial begin
    void'($urandom(6));
    repeat (2) @(negedge clock);
    reset_n = 1;
    repeat (5) @(negedge clock);
    chk_all();
    repeat (4) begin
      wr(2'h0, 24'($urandom));
      wr(2'h1, 24'($urandom) & 24'hdfffff);
      wr(2'h2, 24'($urandom));
    end
    wr(2'h2, 24'h000004);
    wr(2'h0, 24'($urandom));
    wr(2'h1, 24'($urandom) & 24'hdfffff);
    pulse(1);
    chk_all();
    wr(2'h2, 24'h000008);
    wr(2'h2, 24'h080008);
    pulse(1);
    spd = 1;
    chk_all();
    wr(2'h2, 24'h000000);
    chip_activate = 0;
    repeat (4) @(negedge clock);
    chk_all();
    wr(2'h2, 24'($urandom) & 24'hfffff3);
    wr(2'h0, 24'($urandom));
    wr(2'h1, 24'($urandom) & 24'hdfffff);
    chip_activate = 1;
    repeat (4) @(negedge clock);
    chk_all();
    wr(2'h2, 24'h000200);
    wr(2'h1, 24'h200000);
    pulse(64);
    chk_all();
    wr(2'h1, 24'h000000);
    f = {3'($urandom), 1'b1};
    n = 3 + 4 * f;
    wr(2'h2, {9'h000, f, 11'h200});
    wr(2'h1, 24'h200000);
    pulse(n - 1);
    chk_all();
    pulse(1);
    boost = 0;
    chk_all();
    wr(2'h3, 24'h000008);
    wr(2'h3, 24'h000000);
    wr(2'h0, 24'($urandom));
    wr(2'h1, 24'($urandom) & 24'hdfffff);
    wr(2'h1, 24'($urandom) & 24'hdfffff);
    end_of_test();
  end
endmodule
bind plf_top plf_top_properties #(.WORD_W(WORD_W)) i_props (.*);
`default_nettype wire
